//--- include/dtc_pkg.sv
// Purpose: Shared constants for the trigger and configuration register bank
// Assumes: 16-bit register words, 8-bit register addresses
// Notes:   Code fields are left aligned in bits 11..2 of each code register
package dtc_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_OUT_CODE = 8'h21;
  localparam logic [7:0] ADDR_UPPER    = 8'h25;
  localparam logic [7:0] ADDR_LOWER    = 8'h26;
  localparam logic [7:0] ADDR_ADDR_CFG = 8'hD2;
  localparam logic [7:0] ADDR_TRIGGER  = 8'hD3;
  // Reset values
  localparam logic [15:0] RST_ADDR_CFG = 16'h0000;
  localparam logic [15:0] RST_TRIGGER  = 16'h0008;
  localparam logic [9:0]  RST_CODE     = 10'h000;
  // Code field position and width
  localparam int CODE_LSB = 2;
  localparam int CODE_W   = 10;
  // Address/input configuration fields
  localparam int ADDR_LO_LSB  = 14;
  localparam int PIN_FUNC_LSB = 11;
  // Trigger fields
  localparam int UNLOCK_LSB    = 12;
  localparam int PIN_EN_BIT    = 10;
  localparam int FACTORY_BIT   = 9;
  localparam int WAVE_RUN_BIT  = 8;
  localparam int MARGIN_HI_BIT = 7;
  localparam int MARGIN_LO_BIT = 6;
  localparam int RECALL_BIT    = 5;
  localparam int STORE_WR_BIT  = 4;
  localparam logic [3:0] UNLOCK_KEY   = 4'h5;
  localparam logic [3:0] RESTART_IDLE = 4'h8;
  localparam logic [3:0] RESTART_GO   = 4'hA;
  // Waveform shapes
  typedef enum logic [1:0] {
    DTC_TRIANGLE  = 2'h0,
    DTC_SAW_UP    = 2'h1,
    DTC_SAW_DOWN  = 2'h2,
    DTC_SQUARE    = 2'h3
  } dtc_shape_t;
  // Store access states
  typedef enum logic [1:0] {ST_IDLE, ST_RECALL, ST_WRITE} dtc_store_t;
endpackage

//--- include/dtc_wave_if.sv
// Purpose: Carrier between the register bank and the code engine
// Assumes: Both ends run on core_clk
// Notes:   Load has priority over any stepping in the engine
`timescale 1ns/1ps
`default_nettype none
interface dtc_wave_if #(parameter int CW = 10);
  logic [CW-1:0] upper;      // Upper margin code
  logic [CW-1:0] lower;      // Lower margin code
  logic          runWave;    // Continuous waveform enable
  logic [1:0]    shape;      // Waveform shape select
  logic          marginHi;   // Move toward upper margin
  logic          marginLo;   // Move toward lower margin
  logic [15:0]   stepCycles; // Clock cycles per step, less one
  logic          load;       // Force active code
  logic [CW-1:0] loadValue;  // Value forced on load
  logic [CW-1:0] code;       // Active output code
  logic          hiReached;  // Code equals upper margin
  logic          loReached;  // Code equals lower margin
  modport bank (output upper, lower, runWave, shape, marginHi, marginLo,
                stepCycles, load, loadValue,
                input code, hiReached, loReached);
  modport engine (input upper, lower, runWave, shape, marginHi, marginLo,
                  stepCycles, load, loadValue,
                  output code, hiReached, loReached);
endinterface
`default_nettype wire

//--- verilog/dtc_wave_engine.sv
// Purpose: Active code engine for margin moves and waveform generation
// Assumes: Margin codes satisfy lower <= upper
// Notes:   One code step per step interval; ramps and margin moves go one LSB per step
`timescale 1ns/1ps
`default_nettype none
module dtc_wave_engine
  import dtc_pkg::*;
#(
  parameter int CW = 10
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Bank side
  dtc_wave_if.engine wv
);
  logic [CW-1:0] code_reg;   // Active code
  logic          dirUp_reg;  // Triangle direction
  logic [15:0]   tick_reg;   // Step interval counter
  logic          tick;       // One step due
  dtc_shape_t    shape;      // Typed shape view

  assign shape        = dtc_shape_t'(wv.shape);
  assign tick         = (tick_reg == 16'h0000);
  assign wv.code      = code_reg;
  assign wv.hiReached = (code_reg == wv.upper);
  assign wv.loReached = (code_reg == wv.lower);

  // Step pacing; a zero interval steps every cycle
  always_ff @(posedge core_clk) begin
    if (reset || tick) begin
      tick_reg <= wv.stepCycles;
    end else begin
      tick_reg <= tick_reg - 16'h0001;
    end
  end

  // Active code update, load wins over stepping
  always_ff @(posedge core_clk) begin
    if (reset) begin
      code_reg  <= RST_CODE;
      dirUp_reg <= 1'b1;
    end else if (wv.load) begin
      code_reg <= wv.loadValue;
    end else if (tick && wv.runWave) begin
      case (shape)
        DTC_TRIANGLE: begin
          if (dirUp_reg && code_reg >= wv.upper) begin
            dirUp_reg <= 1'b0;
          end else if (!dirUp_reg && code_reg <= wv.lower) begin
            dirUp_reg <= 1'b1;
          end else if (dirUp_reg) begin
            code_reg <= code_reg + 1'b1;
          end else begin
            code_reg <= code_reg - 1'b1;
          end
        end
        DTC_SAW_UP: begin
          code_reg <= (code_reg >= wv.upper) ? wv.lower : code_reg + 1'b1;
        end
        DTC_SAW_DOWN: begin
          code_reg <= (code_reg <= wv.lower) ? wv.upper : code_reg - 1'b1;
        end
        DTC_SQUARE: begin
          code_reg <= (code_reg == wv.upper) ? wv.lower : wv.upper;
        end
        default: begin
          code_reg <= code_reg;
        end
      endcase
    end else if (tick && wv.marginHi && code_reg != wv.upper) begin
      // Margin high walks toward the upper code
      code_reg <= (code_reg < wv.upper) ? code_reg + 1'b1
                                        : code_reg - 1'b1;
    end else if (tick && wv.marginLo && code_reg != wv.lower) begin
      // Margin low walks toward the lower code
      code_reg <= (code_reg < wv.lower) ? code_reg + 1'b1
                                        : code_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verilog/dtc_regs.sv
// Purpose: Trigger and configuration register bank of a voltage DAC
// Assumes: The bus target front end delivers decoded register accesses
//          on core_clk; store macro answers with a one-cycle done pulse
// Notes:   Write-only registers read back as zero
`timescale 1ns/1ps
`default_nettype none
module dtc_regs
  import dtc_pkg::*;
#(
  parameter int RES_BITS = 10  // 10 or 8 bit code resolution
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Register access from bus front end
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire logic [7:0]  rdAddr,
  output logic      [15:0] rdData,
  // Settings held by the general configuration logic
  input  wire logic        deviceLock,
  input  wire logic [1:0]  waveShape,
  input  wire logic [15:0] stepCycles,
  // Input pin
  input  wire logic        inputPin,
  output logic      [2:0]  pinFunction,
  output logic             pinEvent,
  // Target address and restore strobe
  output logic      [1:0]  targetAddrLow,
  output logic             factoryRestore,
  // Nonvolatile store macro
  output logic             storeReq,
  output logic             storeWrite,
  output logic      [29:0] storeWrData,
  input  wire logic [29:0] storeRdData,
  input  wire logic        storeDone,
  output logic             storeBusy,
  // Active code
  output logic      [9:0]  activeCode
);
  // Code bits kept at this resolution; dropped low bits are zero
  localparam logic [9:0] RES_MASK = 10'h3FF << (CODE_W - RES_BITS);

  // Carrier between the bank and the code engine
  dtc_wave_if #(.CW(CODE_W)) wv ();

  // Register state
  logic [15:0] addrCfg_reg;    // Address/input configuration
  logic        pinEn_reg;      // Input pin enable
  logic        waveRun_reg;    // Continuous waveform run
  logic        marginHi_reg;   // Margin high in progress
  logic        marginLo_reg;   // Margin low in progress
  logic        unlocked_reg;   // Lock bypassed by key
  logic        lockSeen_reg;   // Lock level one cycle ago
  logic [9:0]  outCode_reg;    // Last written output code
  logic [9:0]  upper_reg;      // Upper margin code
  logic [9:0]  lower_reg;      // Lower margin code
  dtc_store_t  store_reg;      // Store access state
  logic        pinMeta_reg;    // Pin synchroniser first stage
  logic        pinSync_reg;    // Pin synchroniser second stage
  logic        pinLast_reg;    // Pin level one cycle ago
  logic        factory_reg;    // Restore strobe
  logic [15:0] rdData_reg;     // Read data
  // Decoded write and command strobes
  logic        locked;         // Writes refused
  logic        wrOk;           // Accepted write
  logic        trigWr;         // Accepted trigger write
  logic        keyWr;          // Unlock key written
  logic        factoryGo;      // Factory restore requested
  logic        restartGo;      // Soft restart requested
  logic        defaults;       // Return registers to defaults
  logic        recallGo;       // Start recall
  logic        writeGo;        // Start store write
  logic        recallDone;     // Recall finished
  logic [9:0]  wrCode;         // Masked code field of write

  // Write qualification
  assign keyWr   = wrEn && wrAddr == ADDR_TRIGGER
                   && wrData[UNLOCK_LSB +: 4] == UNLOCK_KEY;
  assign locked  = deviceLock && !unlocked_reg;
  assign wrOk    = wrEn && !locked;
  assign trigWr  = wrOk && wrAddr == ADDR_TRIGGER;
  assign wrCode  = wrData[CODE_LSB +: CODE_W] & RES_MASK;
  assign factoryGo = trigWr && wrData[FACTORY_BIT];
  assign restartGo = trigWr && wrData[3:0] == RESTART_GO;
  assign defaults  = factoryGo || restartGo;
  // A restart recalls only from idle; recall and store-write commands are dropped while the store is busy
  assign recallGo  = store_reg == ST_IDLE && !factoryGo
                     && (restartGo || (trigWr && wrData[RECALL_BIT]));
  assign writeGo   = store_reg == ST_IDLE && !defaults
                     && trigWr && wrData[STORE_WR_BIT]
                     && !wrData[RECALL_BIT];
  assign recallDone = store_reg == ST_RECALL && storeDone;

  // Lock bypass: set by the key, dropped when the lock is raised again
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unlocked_reg <= 1'b0;
      lockSeen_reg <= 1'b0;
    end else begin
      lockSeen_reg <= deviceLock;
      // The key wins over a clear in the same cycle
      if (keyWr) begin
        unlocked_reg <= 1'b1;
      end else if (defaults || (deviceLock && !lockSeen_reg)) begin
        unlocked_reg <= 1'b0;
      end
    end
  end

  // Address/input configuration; reserved bits kept as written
  // Restart and factory restore clear it just like reset
  always_ff @(posedge core_clk) begin
    if (reset || defaults) begin
      addrCfg_reg <= RST_ADDR_CFG;
    end else if (wrOk && wrAddr == ADDR_ADDR_CFG) begin
      addrCfg_reg <= wrData;
    end
  end

  // Trigger control bits
  // Command bits act as strobes and are never stored here
  always_ff @(posedge core_clk) begin
    if (reset || defaults) begin
      pinEn_reg   <= RST_TRIGGER[PIN_EN_BIT];
      waveRun_reg <= RST_TRIGGER[WAVE_RUN_BIT];
    end else if (trigWr) begin
      pinEn_reg   <= wrData[PIN_EN_BIT];
      waveRun_reg <= wrData[WAVE_RUN_BIT];
    end
  end

  // Margin commands; a new command wins over arrival in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset || defaults) begin
      marginHi_reg <= RST_TRIGGER[MARGIN_HI_BIT];
      marginLo_reg <= RST_TRIGGER[MARGIN_LO_BIT];
    end else if (trigWr) begin
      marginHi_reg <= wrData[MARGIN_HI_BIT];
      marginLo_reg <= wrData[MARGIN_LO_BIT];
    end else begin
      // Hardware drops a command once the code has arrived
      if (wv.hiReached) begin
        marginHi_reg <= 1'b0;
      end
      if (wv.loReached) begin
        marginLo_reg <= 1'b0;
      end
    end
  end

  // Code registers; recall results land here too
  // Factory restore zeroes them; a restart from idle reloads them by recall
  always_ff @(posedge core_clk) begin
    if (reset || factoryGo) begin
      outCode_reg <= RST_CODE;
      upper_reg   <= RST_CODE;
      lower_reg   <= RST_CODE;
    end else if (recallDone) begin
      outCode_reg <= storeRdData[9:0] & RES_MASK;
      upper_reg   <= storeRdData[19:10] & RES_MASK;
      lower_reg   <= storeRdData[29:20] & RES_MASK;
    end else if (wrOk) begin
      // Only the addressed code register changes
      if (wrAddr == ADDR_OUT_CODE) begin
        outCode_reg <= wrCode;
      end
      if (wrAddr == ADDR_UPPER) begin
        upper_reg <= wrCode;
      end
      if (wrAddr == ADDR_LOWER) begin
        lower_reg <= wrCode;
      end
    end
  end

  // Store sequencer; request held until the macro answers
  // One operation at a time; commands meanwhile are dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      store_reg <= ST_IDLE;
    end else begin
      case (store_reg)
        ST_IDLE: begin
          if (recallGo) begin
            store_reg <= ST_RECALL;
          end else if (writeGo) begin
            store_reg <= ST_WRITE;
          end
        end
        ST_RECALL, ST_WRITE: begin
          // Done closes the operation; recalled codes land now
          if (storeDone) begin
            store_reg <= ST_IDLE;
          end
        end
        default: begin
          store_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Busy mirrors the request, so the host sees the whole operation
  assign storeReq    = store_reg != ST_IDLE;
  assign storeWrite  = store_reg == ST_WRITE;
  assign storeBusy   = store_reg != ST_IDLE;
  assign storeWrData = {lower_reg, upper_reg, outCode_reg};

  // Input pin: two stages before any logic looks at it
  // A third stage only remembers the level for edge detection
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta_reg <= 1'b0;
      pinSync_reg <= 1'b0;
      pinLast_reg <= 1'b0;
    end else begin
      pinMeta_reg <= inputPin;
      pinSync_reg <= pinMeta_reg;
      pinLast_reg <= pinSync_reg;
    end
  end

  // Pin edge only acts while enabled
  assign pinEvent    = pinEn_reg && pinSync_reg && !pinLast_reg;
  assign pinFunction = addrCfg_reg[PIN_FUNC_LSB +: 3];
  assign targetAddrLow = addrCfg_reg[ADDR_LO_LSB +: 2];

  // Restore strobe for the general configuration logic
  // Registered, so the pulse is clean one cycle after the write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      factory_reg <= 1'b0;
    end else begin
      factory_reg <= factoryGo;
    end
  end
  assign factoryRestore = factory_reg;

  // Read port; write-only and unmapped addresses return zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdData_reg <= 16'h0000;
    end else if (rdEn) begin
      case (rdAddr)
        ADDR_ADDR_CFG: begin
          rdData_reg <= addrCfg_reg;
        end
        // Write-only trigger fields read back as zero
        ADDR_TRIGGER: begin
          rdData_reg <= {5'h00, pinEn_reg, 2'h0, marginHi_reg,
                         marginLo_reg, 6'h00};
        end
        default: begin
          rdData_reg <= 16'h0000;
        end
      endcase
    end
  end
  assign rdData = rdData_reg;

  // Engine connections; waveform and margin share the engine
  // The engine gives waveform mode priority over margin moves
  assign wv.upper      = upper_reg;
  assign wv.lower      = lower_reg;
  assign wv.runWave    = waveRun_reg;
  assign wv.shape      = waveShape;
  assign wv.marginHi   = marginHi_reg;
  assign wv.marginLo   = marginLo_reg;
  assign wv.stepCycles = stepCycles;
  // Direct write or recall forces the active code at once
  assign wv.load       = recallDone || factoryGo
                         || (wrOk && wrAddr == ADDR_OUT_CODE);
  assign wv.loadValue  = recallDone ? (storeRdData[9:0] & RES_MASK)
                         : (factoryGo ? RST_CODE : wrCode);
  assign activeCode    = wv.code;

  // Code engine
  dtc_wave_engine #(.CW(CODE_W)) u_engine (
    .core_clk (core_clk),
    .reset    (reset),
    .wv       (wv.engine)
  );
endmodule
`default_nettype wire

//--- verif/dtc_regs_properties.sv
// Purpose: Port-level properties of the trigger and config register bank
// Assumes: One clock, synchronous active-high reset, RES_BITS of 10
// Notes:   Unlock state is rebuilt here from the bus traffic
`timescale 1ns/1ps
`default_nettype none
module dtc_regs_properties
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Register access
  input wire logic        wrEn,
  input wire logic [7:0]  wrAddr,
  input wire logic [15:0] wrData,
  input wire logic        rdEn,
  input wire logic [7:0]  rdAddr,
  input wire logic [15:0] rdData,
  input wire logic        deviceLock,
  // Watched outputs and store handshake
  input wire logic [2:0]  pinFunction,
  input wire logic [1:0]  targetAddrLow,
  input wire logic        factoryRestore,
  input wire logic        storeReq,
  input wire logic        storeWrite,
  input wire logic [29:0] storeRdData,
  input wire logic        storeDone,
  input wire logic        storeBusy,
  input wire logic [9:0]  activeCode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic        unlocked_reg;  // Key seen since the lock rose
  logic [15:0] lastWr_reg;    // Write data one cycle back
  logic [9:0]  lastRd_reg;    // Recalled output code one cycle back
  wire trgWr = wrEn && wrAddr == ADDR_TRIGGER;
  wire okWr  = wrEn && (!deviceLock || unlocked_reg);
  // Key writes apply nothing else while locked, so they are left out here
  wire okTrg = okWr && trgWr && wrData[15:12] != UNLOCK_KEY;
  wire facCmd = okTrg && wrData[9];
  // Cleared on anything that may drop the key, so never too generous
  always_ff @(posedge core_clk) begin
    if (reset || $rose(deviceLock)) begin
      unlocked_reg <= 1'b0;
    end else if (trgWr && wrData[15:12] == UNLOCK_KEY) begin
      unlocked_reg <= 1'b1;
    end else if (trgWr && (wrData[9] || wrData[3:0] == RESTART_GO)) begin
      unlocked_reg <= 1'b0;
    end
  end
  // Snapshots for the one-cycle-later comparisons
  always_ff @(posedge core_clk) begin
    lastWr_reg <= wrData;
    lastRd_reg <= storeRdData[9:0];
  end
  property p_code_load;
    okWr && wrAddr == ADDR_OUT_CODE && !storeDone
      |=> activeCode == lastWr_reg[11:2];
  endproperty
  a_code_load: assert property (p_code_load)
    else $error("output code write not applied");
  property p_cfg_load;
    okWr && wrAddr == ADDR_ADDR_CFG && !storeDone |=>
      targetAddrLow == lastWr_reg[15:14] && pinFunction == lastWr_reg[13:11];
  endproperty
  a_cfg_load: assert property (p_cfg_load)
    else $error("config write not applied");
  property p_lock_hold;
    wrEn && deviceLock && !unlocked_reg && wrAddr == ADDR_ADDR_CFG
      && !storeDone |=> $stable(targetAddrLow) && $stable(pinFunction);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("locked config write changed outputs");
  property p_factory;
    facCmd |=> factoryRestore ##1 !factoryRestore;
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory restore pulse wrong");
  property p_factory_cause;
    factoryRestore |-> $past(facCmd);
  endproperty
  a_factory_cause: assert property (p_factory_cause)
    else $error("factory restore without command");
  property p_wo_read;
    rdEn && (rdAddr == ADDR_OUT_CODE || rdAddr == ADDR_UPPER
      || rdAddr == ADDR_LOWER) |=> rdData == 16'h0000;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register read nonzero");
  property p_trig_read;
    rdEn && rdAddr == ADDR_TRIGGER |=> (rdData & 16'hFB3F) == 16'h0000;
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("trigger read shows write-only bits");
  property p_busy_end;
    storeReq && storeDone |=> !storeReq && !storeBusy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy not released after done");
  property p_store_go;
    okTrg && !storeReq && wrData[4] && !wrData[5] && !wrData[9]
      && wrData[3:0] != RESTART_GO |=> storeBusy && storeWrite;
  endproperty
  a_store_go: assert property (p_store_go)
    else $error("store write did not start");
  property p_recall_go;
    okTrg && !storeReq && (wrData[5] || wrData[3:0] == RESTART_GO)
      && !wrData[9] |=> storeBusy && !storeWrite;
  endproperty
  a_recall_go: assert property (p_recall_go)
    else $error("recall did not start");
  property p_recall;
    storeReq && !storeWrite && storeDone |=> activeCode == lastRd_reg;
  endproperty
  a_recall: assert property (p_recall)
    else $error("recalled code not applied");
  c_factory: cover property (facCmd);
  c_recall: cover property (storeReq && !storeWrite && storeDone);
  c_store: cover property (storeReq && storeWrite && storeDone);
endmodule
bind dtc_regs dtc_regs_properties u_props (.*);
`default_nettype wire

//--- verif/dtc_store_model.sv
// Purpose: Behavioural nonvolatile store macro facing the register bank
// Assumes: Requests hold until the done pulse
// Notes:   Read data is garbage outside the done cycle
`timescale 1ns/1ps
`default_nettype none
module dtc_store_model
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Answer delay chosen by the bench
  input  wire logic [3:0]  latency,
  // Store port
  input  wire logic        storeReq,
  input  wire logic        storeWrite,
  input  wire logic [29:0] storeWrData,
  output logic      [29:0] storeRdData,
  output logic             storeDone
);
  logic [29:0] cell_reg;  // Stored word
  logic [3:0]  wait_reg;  // Cycles into the request
  // Elapsed time of the running request
  always_ff @(posedge core_clk) begin
    if (reset || !storeReq) begin
      wait_reg <= 4'h0;
    end else if (wait_reg != 4'hF) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // One done pulse per request, prompt or slow
  always_ff @(posedge core_clk) begin
    storeDone <= !reset && storeReq && !storeDone && wait_reg == latency;
  end
  // Programming lands with the done pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cell_reg <= 30'h00000000;
    end else if (storeDone && storeWrite) begin
      cell_reg <= storeWrData;
    end
  end
  // Inverted word off the done cycle, so stale data never passes
  assign storeRdData = storeDone ? cell_reg : ~cell_reg;
endmodule
`default_nettype wire

//--- verif/dac_trigger_config_registers_tb.sv
// Purpose: Self-checking bench for the trigger and config register bank
// Assumes: Store model answers in a latency set per test
// Notes:   Expectations queue up; a watcher compares on each result
`timescale 1ns/1ps
`default_nettype none
module dac_trigger_config_registers_tb;
  import dtc_pkg::*;
  typedef struct packed {logic [2:0] sel; logic [15:0] val;} dtc_note_t;
  logic        core_clk, reset, wrEn, rdEn, deviceLock, inputPin;
  logic        pinEvent, factoryRestore, storeReq, storeWrite;
  logic        storeDone, storeBusy, pend, lookEn;
  logic [7:0]  wrAddr, rdAddr;
  logic [15:0] wrData, rdData, stepCycles, probeVal, obs;
  logic [1:0]  waveShape, targetAddrLow;
  logic [2:0]  pinFunction;
  logic [29:0] storeWrData, storeRdData;
  logic [9:0]  activeCode, mx, mn, prev;
  logic [3:0]  latency;
  logic [31:0] rng;
  int          n_mismatch, n_compared, cyc, pinCount, ups, dns;
  dtc_note_t   expQ[$];
  dtc_note_t   note;
  dtc_regs uut (.*);
  dtc_store_model model (.*);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bus cycles: one strobe cycle, then a gap
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    wrEn = 1'b1;
    wrAddr = a;
    wrData = d;
    @(negedge core_clk);
    wrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge core_clk);
    rdEn = 1'b1;
    rdAddr = a;
    expQ.push_back('{3'h0, e});
    @(negedge core_clk);
    rdEn = 1'b0;
  endtask
  // Sample an output: 1 code, 2 address, 3 pin function, 4 busy, 5 events
  task automatic look(input logic [2:0] s, input logic [15:0] e);
    @(negedge core_clk);
    lookEn = 1'b1;
    expQ.push_back('{s, e});
    @(negedge core_clk);
    lookEn = 1'b0;
  endtask
  task automatic wait_idle(input logic [9:0] c);
    int k;
    k = 0;
    while ((storeBusy !== 1'b0 || activeCode !== c) && k < 200) begin
      @(negedge core_clk);
      k++;
    end
  endtask
  // Watcher: the result lands one cycle after its strobe
  always @(posedge core_clk) pend <= rdEn | lookEn;
  always @(negedge core_clk) begin
    if (pend === 1'b1) begin
      note = expQ.pop_front();
      case (note.sel)
        3'h0: obs = rdData;
        3'h1: obs = {6'h00, activeCode};
        3'h2: obs = {14'h0000, targetAddrLow};
        3'h3: obs = {13'h0000, pinFunction};
        3'h4: obs = {15'h0000, storeBusy};
        3'h5: obs = pinCount[15:0];
        default: obs = probeVal;
      endcase
      n_compared++;
      if (obs !== note.val) begin
        n_mismatch++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, note.val, obs);
      end
    end
  end
  // Pin event counter and hang guard
  always @(posedge core_clk) begin
    pinCount <= reset ? 0 : pinCount + int'(pinEvent === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    reset = 1'b1;
    {wrEn, rdEn, lookEn, deviceLock, inputPin} = 5'h00;
    {wrAddr, rdAddr, wrData, probeVal} = 48'h000000000000;
    {waveShape, latency} = 6'h00;
    stepCycles = 16'h0007;
    rng = 32'h00009E68;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    rd(ADDR_TRIGGER, 16'h0000);
    rd(8'h40, 16'h0000);
    look(3'h1, 16'h0000);
    $display("test reset done");
    wr(ADDR_ADDR_CFG, 16'hA800);
    look(3'h2, 16'h0002);
    look(3'h3, 16'h0005);
    rd(ADDR_ADDR_CFG, 16'hA800);
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      wr(ADDR_OUT_CODE, rng[15:0]);
      look(3'h1, {6'h00, rng[11:2]});
      rd(ADDR_UPPER, 16'h0000);
    end
    $display("test codes done");
    wr(ADDR_OUT_CODE, 16'h0100);
    for (int j = 0; j < 2; j++) begin
      wr(j ? ADDR_LOWER : ADDR_UPPER, j ? 16'h00F8 : 16'h0110);
      wr(ADDR_TRIGGER, j ? 16'h0048 : 16'h0088);
      rd(ADDR_TRIGGER, j ? 16'h0040 : 16'h0080);
      wait_idle(j ? 10'h03E : 10'h044);
      rd(ADDR_TRIGGER, 16'h0000);
      look(3'h1, j ? 16'h003E : 16'h0044);
    end
    $display("test margins done");
    stepCycles = 16'h0000;
    for (int s = 0; s < 4; s++) begin
      waveShape = s[1:0];
      wr(ADDR_TRIGGER, 16'h0108);
      {mx, mn, ups, dns} = {10'h000, 10'h3FF, 64'h0};
      repeat (10) @(negedge core_clk);
      prev = activeCode;
      repeat (60) begin
        @(negedge core_clk);
        if (activeCode > mx) mx = activeCode;
        if (activeCode < mn) mn = activeCode;
        if (activeCode == prev + 10'h001) ups++;
        if (activeCode + 10'h001 == prev) dns++;
        prev = activeCode;
      end
      probeVal = {ups > 0, dns > 0, mx[6:0], mn[6:0]};
      look(3'h6, {2'h3 - s[1:0], 14'h223E});
      wr(ADDR_TRIGGER, 16'h0008);
    end
    $display("test waveforms done");
    wr(ADDR_OUT_CODE, 16'h0ABC);
    latency = 4'h9;
    wr(ADDR_TRIGGER, 16'h0018);
    look(3'h4, 16'h0001);
    wait_idle(10'h2AF);
    wr(ADDR_OUT_CODE, 16'h0004);
    latency = 4'h0;
    wr(ADDR_TRIGGER, 16'h0028);
    wait_idle(10'h2AF);
    look(3'h1, 16'h02AF);
    wr(ADDR_ADDR_CFG, 16'h4000);
    wr(ADDR_OUT_CODE, 16'h0004);
    latency = 4'h3;
    wr(ADDR_TRIGGER, 16'h000A);
    wait_idle(10'h2AF);
    look(3'h2, 16'h0000);
    look(3'h1, 16'h02AF);
    wr(ADDR_ADDR_CFG, 16'hC000);
    wr(ADDR_TRIGGER, 16'h0208);
    look(3'h2, 16'h0000);
    look(3'h1, 16'h0000);
    $display("test store done");
    deviceLock = 1'b1;
    wr(ADDR_ADDR_CFG, 16'hC000);
    look(3'h2, 16'h0000);
    wr(ADDR_TRIGGER, 16'h5008);
    wr(ADDR_ADDR_CFG, 16'h8800);
    look(3'h2, 16'h0002);
    deviceLock = 1'b0;
    $display("test lock done");
    for (int p = 0; p < 2; p++) begin
      if (p == 1) wr(ADDR_TRIGGER, 16'h0408);
      inputPin = 1'b1;
      repeat (6) @(negedge core_clk);
      inputPin = 1'b0;
      look(3'h5, p[15:0]);
    end
    $display("test pin done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
